/* File: rtl/crc_ctrl.sv */
// control registers and real-time output pin 0 multiplexer
`timescale 1ns/1ns
module crc_ctrl
   import crc_pkg::*;
(
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic CE,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // video timing and status from the decoder core
   input wire logic LOCK_STD,
   input wire logic LOCK_FAST,
   input wire logic VLOCK,
   input wire logic COLOUR_DET,
   input wire logic LINE_REF,
   input wire logic HSYNC_RAW,
   input wire logic VSYNC,
   input wire logic VWIN,
   input wire logic FIELD,
   input wire logic ADC_LSB,
   // decoder steering
   output logic [1:0] BLUE_FINE_OFS,
   output logic [1:0] RED_FINE_OFS,
   output logic BAND_WIDE,
   output logic [2:0] BAND_BALANCE,
   output logic FORCE_CHROMA_ON,
   output logic [2:0] LUMA_DELAY,
   output logic OUT1_INVERT,
   // real-time output pin 0
   output logic RT0_O,
   output logic RT0_OE
);

   typedef struct packed {
      logic [7:0] chroma_r;
      logic [7:0] mode_r;
      logic [7:0] sel_r;
      logic [7:0] lock_r;
      logic [7:0] rdata_r;
      logic [1:0] clk_div_r;
      logic [DELAY_MAX-1:0] hs_pipe_r;
      logic [1:0] s1_r;
      logic [1:0] s2_r;
      logic rt0_r;
      logic oe_r;
   } crc_state_t;

   crc_state_t st_r;
   crc_state_t st_nxt;
   logic sel_val;
   logic hs_del;
   logic [2:0] hs_tap;

   // register read decode, used by the bus answer
   function automatic logic [7:0] read_mux(input logic [7:0] a,
                                           input crc_state_t s);
      case (a)
         OFS_CHROMA_CTRL: read_mux = s.chroma_r;
         OFS_MODE_DELAY: read_mux = s.mode_r;
         OFS_RT_SELECT: read_mux = s.sel_r;
         OFS_LOCK_CTRL: read_mux = s.lock_r;
         default: read_mux = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // sync delay tap: fine step times two clocks, shift register depth
   always_comb begin
      hs_tap = 3'(st_r.mode_r[POS_SYNC_FINE +: 2] * STEP_CLOCKS);
      hs_del = (hs_tap == 3'h0) ? st_r.s2_r[1]
               : st_r.hs_pipe_r[hs_tap - 3'h1];
   end

   ////////////////////////////////////////////////////////////////////
   // source selection for pin 0; reserved codes drive low
   always_comb begin
      case (crc_sel_t'(st_r.sel_r[3:0]))
         SEL_LOW: sel_val = 1'b0;
         SEL_CLK: sel_val = st_r.clk_div_r[0];
         SEL_CLK2: sel_val = st_r.clk_div_r[1];
         SEL_HLOCK: sel_val = st_r.lock_r[POS_LOCK_SPEED] ?
                              st_r.s2_r[0] : st_r.s2_r[0] & LOCK_STD;
         SEL_VLOCK: sel_val = VLOCK & LOCK_STD;
         SEL_CLOCK: sel_val = VLOCK & LOCK_STD & COLOUR_DET;
         SEL_LINE: sel_val = LINE_REF;
         SEL_HSYNC: sel_val = hs_del;
         SEL_GLINE: sel_val = LINE_REF & VWIN;
         SEL_VSYNC: sel_val = VSYNC;
         SEL_VWIN: sel_val = VWIN;
         SEL_ADC: sel_val = ADC_LSB;
         SEL_FIELD: sel_val = FIELD;
         default: sel_val = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // next state: registers, dividers, synchronisers, output
   always_comb begin
      st_nxt = st_r;
      // fast lock and raw sync inputs arrive from the slow detector domain
      st_nxt.s1_r = {HSYNC_RAW, LOCK_FAST};
      st_nxt.s2_r = st_r.s1_r;
      st_nxt.clk_div_r = st_r.clk_div_r + 2'h1;
      st_nxt.hs_pipe_r = {st_r.hs_pipe_r[DELAY_MAX-2:0], st_r.s2_r[1]};
      if (WR) begin
         case (ADDR)
            OFS_CHROMA_CTRL: st_nxt.chroma_r = WDATA;
            OFS_MODE_DELAY: st_nxt.mode_r = WDATA;
            OFS_RT_SELECT: st_nxt.sel_r = WDATA;
            OFS_LOCK_CTRL: st_nxt.lock_r = WDATA;
            default: st_nxt.rdata_r = st_r.rdata_r;
         endcase
      end
      st_nxt.rdata_r = RD ? read_mux(ADDR, st_r) : 8'h00;
      st_nxt.oe_r = (st_r.sel_r[3:0] != SEL_FLOAT);
      st_nxt.rt0_r = sel_val ^ st_r.mode_r[POS_OUT0_INV];
   end

   // single state register, frozen while the enable is low
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_r <= '0;
         st_r.chroma_r <= RST_CHROMA_CTRL;
         st_r.mode_r <= RST_MODE_DELAY;
         st_r.sel_r <= RST_RT_SELECT;
         st_r.lock_r <= RST_LOCK_CTRL;
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign RDATA = st_r.rdata_r;
   assign BLUE_FINE_OFS = st_r.chroma_r[POS_BLUE_OFS +: 2];
   assign RED_FINE_OFS = st_r.chroma_r[POS_RED_OFS +: 2];
   assign BAND_WIDE = st_r.chroma_r[POS_BAND_WIDE];
   assign BAND_BALANCE = st_r.chroma_r[2:0];
   assign FORCE_CHROMA_ON = st_r.mode_r[POS_FORCE_CHROMA];
   assign LUMA_DELAY = st_r.mode_r[2:0];
   assign OUT1_INVERT = st_r.mode_r[POS_OUT1_INV];
   assign RT0_O = st_r.rt0_r;
   assign RT0_OE = st_r.oe_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   // short views of the selector and the pin 0 polarity bit
   logic [3:0] chk_sel;
   logic chk_inv;
   assign chk_sel = st_r.sel_r[3:0];
   assign chk_inv = st_r.mode_r[POS_OUT0_INV];

   ////////////////////////////////////////////////////////////////////
   // pin enable follows the selector one cycle later
   float_pin_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_FLOAT |-> !RT0_OE)
      else $error("pin 0 driven while floating selected");

   // every other code drives the pin
   drive_pin_a: assert property (
      $past(CE) && $past(chk_sel) != SEL_FLOAT |-> RT0_OE)
      else $error("pin 0 not driven for a driving code");

   // constant low still obeys the polarity bit
   low_pin_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_LOW |-> RT0_O == $past(chk_inv))
      else $error("constant low output wrong polarity");

   ////////////////////////////////////////////////////////////////////
   // register port: write then read back of the mode register
   read_back_a: assert property (
      CE && WR && ADDR == OFS_MODE_DELAY ##1
      CE && RD && ADDR == OFS_MODE_DELAY |=> RDATA == $past(WDATA, 2))
      else $error("mode register read back mismatch");

   // chroma bandwidth select lands one cycle after the write
   chroma_write_a: assert property (
      CE && WR && ADDR == OFS_CHROMA_CTRL |=>
      BAND_WIDE == $past(WDATA[3]) && BLUE_FINE_OFS == $past(WDATA[7:6]))
      else $error("chroma control not stored");

   // blue difference fine offset field
   blue_ofs_a: assert property (
      CE && WR && ADDR == OFS_CHROMA_CTRL |=>
      BLUE_FINE_OFS == $past(WDATA[7:6]))
      else $error("blue fine offset not stored");

   // red difference fine offset field
   red_ofs_a: assert property (
      CE && WR && ADDR == OFS_CHROMA_CTRL |=>
      RED_FINE_OFS == $past(WDATA[5:4]))
      else $error("red offset not stored");

   // chroma against luma balance field
   balance_a: assert property (
      CE && WR && ADDR == OFS_CHROMA_CTRL |=>
      BAND_BALANCE == $past(WDATA[2:0]))
      else $error("band balance not stored");

   // colour killer override
   force_col_a: assert property (
      CE && WR && ADDR == OFS_MODE_DELAY |=>
      FORCE_CHROMA_ON == $past(WDATA[7]))
      else $error("colour force not stored");

   // pin 1 polarity is only steered out, pin 1 itself lives elsewhere
   out1_inv_a: assert property (
      CE && WR && ADDR == OFS_MODE_DELAY |=>
      OUT1_INVERT == $past(WDATA[6]))
      else $error("pin 1 invert not stored");

   // signed luma delay passes as written, sign kept in bit 2
   luma_delay_a: assert property (
      CE && WR && ADDR == OFS_MODE_DELAY |=>
      LUMA_DELAY == $past(WDATA[2:0]))
      else $error("luma delay not stored");

   ////////////////////////////////////////////////////////////////////
   // full rate reference flips on every enabled clock
   half_clk_a: assert property (
      $past(CE) && $past(CE, 2) &&
      $past(chk_sel) == SEL_CLK && $past(chk_sel, 2) == SEL_CLK &&
      $past(chk_inv) == $past(chk_inv, 2) |-> RT0_O != $past(RT0_O))
      else $error("reference clock not toggling");

   // half rate reference flips every second enabled clock
   quarter_clk_a: assert property (
      $past(CE) && $past(CE, 2) && $past(CE, 3) &&
      $past(chk_sel) == SEL_CLK2 && $past(chk_sel, 3) == SEL_CLK2 &&
      $past(chk_inv) == $past(chk_inv, 3) |-> RT0_O != $past(RT0_O, 2))
      else $error("half rate reference not toggling");

   ////////////////////////////////////////////////////////////////////
   // fast lock detector alone when the speed bit is set
   hlock_fast_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_HLOCK &&
      $past(st_r.lock_r[POS_LOCK_SPEED]) |->
      RT0_O == ($past(st_r.s2_r[0]) ^ $past(chk_inv)))
      else $error("fast horizontal lock wrong");

   // fast and standard detectors together otherwise
   hlock_std_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_HLOCK &&
      !$past(st_r.lock_r[POS_LOCK_SPEED]) |->
      RT0_O == ($past(st_r.s2_r[0] & LOCK_STD) ^ $past(chk_inv)))
      else $error("standard horizontal lock wrong");

   // vertical plus horizontal lock
   vlock_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_VLOCK |->
      RT0_O == ($past(VLOCK & LOCK_STD) ^ $past(chk_inv)))
      else $error("vertical lock indicator wrong");

   // both locks with colour detected
   full_lock_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_CLOCK |->
      RT0_O == ($past(VLOCK & LOCK_STD & COLOUR_DET) ^ $past(chk_inv)))
      else $error("full lock indicator wrong");

   ////////////////////////////////////////////////////////////////////
   // active line reference passes straight through
   line_ref_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_LINE |->
      RT0_O == ($past(LINE_REF) ^ $past(chk_inv)))
      else $error("line reference wrong");

   // zero fine position: synchronised sync, no extra delay
   sync_zero_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_HSYNC &&
      $past(st_r.mode_r[POS_SYNC_FINE +: 2]) == 2'h0 |->
      RT0_O == ($past(st_r.s2_r[1]) ^ $past(chk_inv)))
      else $error("horizontal sync at zero fine position wrong");

   // one fine step is two clocks later than zero
   sync_step_a: assert property (
      $past(CE) && $past(CE, 2) && $past(CE, 3) &&
      $past(chk_sel) == SEL_HSYNC &&
      $past(st_r.mode_r[POS_SYNC_FINE +: 2]) == 2'h1 |->
      RT0_O == ($past(st_r.s2_r[1], 3) ^ $past(chk_inv)))
      else $error("horizontal sync fine step wrong");

   // gated line reference stays inactive outside the window
   window_gate_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_GLINE && !$past(VWIN) |->
      RT0_O == $past(chk_inv))
      else $error("gated line reference active outside window");

   // vertical sync passes straight through
   vsync_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_VSYNC |->
      RT0_O == ($past(VSYNC) ^ $past(chk_inv)))
      else $error("vertical sync wrong");

   // vertical window signal passes straight through
   vwin_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_VWIN |->
      RT0_O == ($past(VWIN) ^ $past(chk_inv)))
      else $error("vertical window signal wrong");

   // converter least significant bit
   adc_lsb_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_ADC |->
      RT0_O == ($past(ADC_LSB) ^ $past(chk_inv)))
      else $error("converter bit wrong");

   // field identifier
   field_id_a: assert property (
      $past(CE) && $past(chk_sel) == SEL_FIELD |->
      RT0_O == ($past(FIELD) ^ $past(chk_inv)))
      else $error("field identifier wrong");

   // reserved codes are held low so a stray write cannot glitch the pin
   reserved_low_a: assert property (
      $past(CE) && ($past(chk_sel) == SEL_RSV7 ||
      $past(chk_sel) == SEL_RSVB) |-> RT0_O == $past(chk_inv))
      else $error("reserved code not held low");

   ////////////////////////////////////////////////////////////////////
   // read data stand only in the cycle after the strobe
   rdata_idle_a: assert property (
      $past(CE) && !$past(RD) |-> RDATA == 8'h00)
      else $error("read data present without a read");

   // holes in the map read as zero
   unmapped_read_a: assert property (
      $past(CE) && $past(RD) && $past(ADDR) > OFS_LOCK_CTRL |->
      RDATA == 8'h00)
      else $error("unmapped read not zero");

   // a low enable freezes every flip-flop, writes included
   freeze_a: assert property (
      !$past(CE) |-> $stable(st_r))
      else $error("state moved while enable low");

   cov_hsync_c: cover property (st_r.sel_r[3:0] == SEL_HSYNC && RT0_O);
   cov_field_c: cover property (st_r.sel_r[3:0] == SEL_FIELD && RT0_O);
   cov_invert_c: cover property (st_r.mode_r[3] && RT0_OE);
   cov_freeze_c: cover property (!CE && WR);
endmodule

/* File: rtl/crc_pkg.sv */
// constants of the chroma delay and real-time output control block
package crc_pkg;
   localparam logic [7:0] OFS_CHROMA_CTRL = 8'h10;
   localparam logic [7:0] OFS_MODE_DELAY = 8'h11;
   localparam logic [7:0] OFS_RT_SELECT = 8'h12;
   localparam logic [7:0] OFS_LOCK_CTRL = 8'h13;
   localparam logic [7:0] RST_CHROMA_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE_DELAY = 8'h00;
   localparam logic [7:0] RST_RT_SELECT = 8'h00;
   localparam logic [7:0] RST_LOCK_CTRL = 8'h00;
   localparam int POS_BLUE_OFS = 6;
   localparam int POS_RED_OFS = 4;
   localparam int POS_BAND_WIDE = 3;
   localparam int POS_FORCE_CHROMA = 7;
   localparam int POS_OUT1_INV = 6;
   localparam int POS_SYNC_FINE = 4;
   localparam int POS_OUT0_INV = 3;
   localparam int POS_LOCK_SPEED = 3;
   // two line-locked clocks per fine step
   localparam int STEP_CLOCKS = 2;
   localparam int DELAY_MAX = 8;
   typedef enum logic [3:0] {
      SEL_FLOAT = 4'h0, SEL_LOW = 4'h1, SEL_CLK = 4'h2, SEL_CLK2 = 4'h3,
      SEL_HLOCK = 4'h4, SEL_VLOCK = 4'h5, SEL_CLOCK = 4'h6, SEL_RSV7 = 4'h7,
      SEL_LINE = 4'h8, SEL_HSYNC = 4'h9, SEL_GLINE = 4'hA, SEL_RSVB = 4'hB,
      SEL_VSYNC = 4'hC, SEL_VWIN = 4'hD, SEL_ADC = 4'hE, SEL_FIELD = 4'hF
   } crc_sel_t;
endpackage

/* File: tb/crc_video_sink.sv */
// far-side video logic model watching real-time output pin 0
`timescale 1ns/1ns
module crc_video_sink (
   // driver side of pin 0
   input wire logic clock,
   input wire logic rt0_o,
   input wire logic rt0_oe,
   // level seen on the wire
   output logic pin
);
   logic last_r = 1'b0;
   // no pull on the wire, so a floated pin shows a changing level
   always @(posedge clock) begin
      last_r <= pin;
   end
   assign pin = rt0_oe ? rt0_o : ~last_r;
endmodule

/* File: tb/chroma_delay_rt_output_ctrl_test.sv */
// self-checking bench for the control registers and pin 0 multiplexer
`timescale 1ns/1ns
module chroma_delay_rt_output_ctrl_test;
   import crc_pkg::*;
   logic clock = 0, arst_n = 0, ce = 1, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, p;
   logic [9:0] src = 10'h000;
   logic [1:0] blue, red;
   logic [2:0] bal, luma_delay_comp;
   logic wide, force_on, inv1, rt0_o, rt0_oe, pin;
   int errors = 0, total_checks = 0, cycles = 0, seed = 7;
   crc_ctrl uut (.CLOCK(clock), .ARST_N(arst_n), .CE(ce), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LOCK_STD(src[0]),
      .LOCK_FAST(src[1]), .VLOCK(src[2]), .COLOUR_DET(src[3]),
      .LINE_REF(src[4]), .HSYNC_RAW(src[5]), .VSYNC(src[6]),
      .VWIN(src[7]), .FIELD(src[8]), .ADC_LSB(src[9]),
      .BLUE_FINE_OFS(blue), .RED_FINE_OFS(red), .BAND_WIDE(wide),
      .BAND_BALANCE(bal), .FORCE_CHROMA_ON(force_on), .LUMA_DELAY(luma_delay_comp),
      .OUT1_INVERT(inv1), .RT0_O(rt0_o), .RT0_OE(rt0_oe));
   crc_video_sink sink (.clock(clock), .rt0_o(rt0_o), .rt0_oe(rt0_oe),
      .pin(pin));
   always #4 clock = ~clock;
   ////////////////////////////////////////////////////////////////////
   // shared checks and bus cycles
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task reg_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // expected pin level of each non-clock source code before inversion
   function logic exp_src(input logic [3:0] c, input logic ls,
                          input logic [9:0] s);
      logic hl;
      hl = ls ? s[1] : (s[1] & s[0]);
      case (c)
         4'h1: return 1'b0;
         4'h4: return hl;
         4'h5: return s[0] & s[2];
         4'h6: return s[0] & s[2] & s[3];
         4'h8: return s[4];
         4'h9: return s[5];
         4'hA: return s[4] & s[7];
         4'hC: return s[6];
         4'hD: return s[7];
         4'hE: return s[9];
         default: return s[8];
      endcase
   endfunction
   // sources held still long enough for sync and fine delay to settle
   task pin_case(input logic [3:0] c, input logic inv, input logic ls);
      logic p0, p1, p2;
      @(posedge clock);
      src <= 10'($random(seed));
      reg_write(OFS_MODE_DELAY, {2'h0, ls, inv, inv, 3'h0});
      reg_write(OFS_LOCK_CTRL, {4'h0, ls, 3'h0});
      reg_write(OFS_RT_SELECT, {4'h0, c});
      repeat (12) @(posedge clock);
      #1 p0 = pin;
      @(posedge clock) #1 p1 = pin;
      @(posedge clock) #1 p2 = pin;
      chk(8'(rt0_oe), 8'(c != 4'h0));
      if (c == 4'h2) chk(8'(p0 ^ p1), 8'h01);
      else if (c == 4'h3) chk(8'(p0 ^ p2), 8'h01);
      else if (c != 4'h0) chk(8'(p0), 8'(exp_src(c, ls, src) ^ inv));
   endtask
   ////////////////////////////////////////////////////////////////////
   // hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      for (int i = 0; i < 4; i++) reg_check(8'h10 + 8'(i), 8'h00);
      reg_write(8'h20, 8'hFF);
      reg_check(8'h20, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         p = 8'($random(seed));
         reg_write(OFS_CHROMA_CTRL, v);
         reg_write(OFS_MODE_DELAY, p);
         // fields change on the edge just passed, look once settled
         #1;
         chk(8'(blue), 8'(v[7:6]));
         chk(8'(red), 8'(v[5:4]));
         chk(8'(wide), 8'(v[3]));
         chk(8'(bal), 8'(v[2:0]));
         chk(8'(force_on), 8'(p[7]));
         chk(8'(inv1), 8'(p[6]));
         chk(8'(luma_delay_comp), 8'(p[2:0]));
         reg_check(OFS_MODE_DELAY, p);
      end
      // a write with the enable low must leave the register alone
      @(posedge clock);
      ce <= 1'b0;
      reg_write(OFS_CHROMA_CTRL, ~v);
      ce <= 1'b1;
      reg_check(OFS_CHROMA_CTRL, v);
      // reserved codes 0111 and 1011 are never written
      for (int c = 0; c < 16; c++) begin
         for (int k = 0; k < 4; k++) begin
            if (c != 7 && c != 11) pin_case(4'(c), k[0], k[1]);
         end
      end
      report_and_stop;
   end
endmodule
